// ===== logic/ptc_timer.sv
// Local design decisions: the register addresses and register access over Wishbone.
module ptc_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [ptc_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [ptc_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ptc_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin,
  input wire logic sleep_mode,
  output logic overflow_irq
);
  import ptc_pkg::*;

  // Software-visible state.
  logic [BYTE_W-1:0] timer_control;
  logic [BYTE_W-1:0] count_low_byte;
  logic [BYTE_W-1:0] count_high_buffer;
  logic [BYTE_W-1:0] count_high_true;
  logic overflow_flag;
  logic overflow_irq_enable;

  // Internal state.
  logic [SYNC_STAGES-1:0] pin_sync;
  logic pin_prev;
  logic [1:0] inhibit_count;

  // Decoded control fields.
  logic timer_run;
  logic width_select;
  logic clock_source_select;
  logic count_edge_select;
  logic prescaler_bypass;
  logic [PS_W-1:0] prescale_ratio_select;

  // Bus strobes and counting terms.
  logic bus_fire;
  logic wr_low;
  logic wr_high;
  logic wr_intc;
  logic wr_tcon;
  logic rd_low;
  logic edge_hit;
  logic count_tick;
  logic wrap_now;
  logic next_flag;

  ptc_psc_if psc_link();

  // True when the current bus address selects the given register.
  function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] off);
    reg_hit = (adr == off);
    return reg_hit;
  endfunction

  // Control fields are read straight out of the control byte.
  assign timer_run = timer_control[TCON_RUN];
  assign width_select = timer_control[TCON_WIDTH];
  assign clock_source_select = timer_control[TCON_SRC];
  assign count_edge_select = timer_control[TCON_EDGE];
  assign prescaler_bypass = timer_control[TCON_BYPASS];
  assign prescale_ratio_select = timer_control[TCON_PS_LSB +: PS_W];

  // A request is served in the cycle it is first seen, so ack comes one edge later.
  assign bus_fire = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_low = bus_fire && wb_we_i && wb_sel_i[LANE_LOW] && reg_hit(wb_adr_i, OFF_LOW);
  assign wr_high = bus_fire && wb_we_i && wb_sel_i[LANE_LOW] && reg_hit(wb_adr_i, OFF_HIGH);
  assign wr_intc = bus_fire && wb_we_i && wb_sel_i[LANE_LOW] && reg_hit(wb_adr_i, OFF_INTC);
  assign wr_tcon = bus_fire && wb_we_i && wb_sel_i[LANE_LOW] && reg_hit(wb_adr_i, OFF_TCON);
  assign rd_low = bus_fire && !wb_we_i && reg_hit(wb_adr_i, OFF_LOW);

  // Edge detect looks only at the second synchroniser stage and its delayed copy.
  assign edge_hit = count_edge_select ? (pin_prev && !pin_sync[SYNC_STAGES-1])
                                      : (!pin_prev && pin_sync[SYNC_STAGES-1]);

  // Counting needs the run bit, no pending hold-off and a live clock; sleep stops it.
  assign count_tick = timer_run && !sleep_mode && (inhibit_count == INHIBIT_NONE)
                      && (clock_source_select ? edge_hit : 1'b1);

  // The prescaler follows the control byte live, so reassignment needs no stop.
  assign psc_link.tick = count_tick;
  assign psc_link.clear = wr_low && !prescaler_bypass;
  assign psc_link.bypass = prescaler_bypass;
  assign psc_link.ratio_sel = prescale_ratio_select;

  ptc_prescaler #(
    .PSC_W(PSC_W)
  ) u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .psc(psc_link.psc)
  );

  // Wrap is judged on the width in force at the increment.
  assign wrap_now = psc_link.out_tick && !wr_low && (count_low_byte == BYTE_ALL_ONES)
                    && (width_select || (count_high_true == BYTE_ALL_ONES));

  // Hardware set beats a software clear landing in the same cycle.
  always_comb begin
    next_flag = overflow_flag;
    if (wr_intc) begin
      next_flag = wb_dat_i[INTC_IF];
    end
    if (wrap_now) begin
      next_flag = 1'b1;
    end
  end

  // Two-flop synchroniser for the count pin, then one more flop for edge history.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync <= '0;
      pin_prev <= 1'b0;
    end else if (clk_en) begin
      pin_sync <= {pin_sync[SYNC_STAGES-2:0], external_count_pin};
      pin_prev <= pin_sync[SYNC_STAGES-1];
    end
  end

  // Hold-off after a count write; software is expected to pre-adjust the value written.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inhibit_count <= INHIBIT_NONE;
    end else if (clk_en) begin
      if (wr_low) begin
        inhibit_count <= INHIBIT_CYCLES;
      end else if (inhibit_count != INHIBIT_NONE) begin
        inhibit_count <= inhibit_count - INHIBIT_STEP;
      end
    end
  end

  // Control byte comes up all ones, so the timer runs at once in 8-bit bypass mode, counting falling edges of the count pin.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_control <= TCON_RESET;
    end else if (clk_en && wr_tcon) begin
      timer_control <= wb_dat_i[BYTE_W-1:0];
    end
  end

  // Low byte: a write wins over an increment in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_low_byte <= LOW_RESET;
    end else if (clk_en) begin
      if (wr_low) begin
        count_low_byte <= wb_dat_i[BYTE_W-1:0];
      end else if (psc_link.out_tick) begin
        count_low_byte <= count_low_byte + BYTE_ONE;
      end
    end
  end

  // True high byte is reachable only through the buffer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_high_true <= HIGH_RESET;
    end else if (clk_en && !width_select) begin
      if (wr_low) begin
        count_high_true <= count_high_buffer;
      end else if (psc_link.out_tick && (count_low_byte == BYTE_ALL_ONES)) begin
        count_high_true <= count_high_true + BYTE_ONE;
      end
    end
  end

  // Buffer is written directly and, in 16-bit mode only, captures the true high byte on a low read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_high_buffer <= HIGH_BUF_RESET;
    end else if (clk_en) begin
      if (wr_high) begin
        count_high_buffer <= wb_dat_i[BYTE_W-1:0];
      end else if (rd_low && !width_select) begin
        count_high_buffer <= count_high_true;
      end
    end
  end

  // Overflow flag and its enable.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else if (clk_en) begin
      overflow_flag <= next_flag;
      if (wr_intc) begin
        overflow_irq_enable <= wb_dat_i[INTC_IE];
      end
    end
  end

  // Request is gated by the enable and kept low in sleep so it never acts as a wake source.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_irq <= 1'b0;
    end else if (clk_en) begin
      overflow_irq <= next_flag && overflow_irq_enable && !sleep_mode;
    end
  end

  // Bus answer: ack for every address; unmapped reads return zero and writes are dropped.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= WORD_ZERO;
    end else if (clk_en) begin
      wb_ack_o <= bus_fire;
      if (bus_fire && !wb_we_i) begin
        wb_dat_o <= WORD_ZERO;
        if (reg_hit(wb_adr_i, OFF_LOW)) begin
          wb_dat_o[BYTE_W-1:0] <= count_low_byte;
        end else if (reg_hit(wb_adr_i, OFF_HIGH)) begin
          wb_dat_o[BYTE_W-1:0] <= count_high_buffer;
        end else if (reg_hit(wb_adr_i, OFF_INTC)) begin
          wb_dat_o[INTC_IE] <= overflow_irq_enable;
          wb_dat_o[INTC_IF] <= overflow_flag;
        end else if (reg_hit(wb_adr_i, OFF_TCON)) begin
          wb_dat_o[BYTE_W-1:0] <= timer_control;
        end
      end
    end
  end
endmodule

// ===== inc/ptc_pkg.sv
package ptc_pkg;

  // Bus and datapath widths.
  localparam int DATA_W = 32;
  localparam int ADR_W = 4;
  localparam int SEL_W = 4;
  localparam int BYTE_W = 8;
  localparam int PSC_W = 8;
  localparam int PS_W = 3;
  localparam int SYNC_STAGES = 2;

  // Register byte offsets, one aligned word each.
  localparam logic [ADR_W-1:0] OFF_LOW = 4'h0;
  localparam logic [ADR_W-1:0] OFF_HIGH = 4'h4;
  localparam logic [ADR_W-1:0] OFF_INTC = 4'h8;
  localparam logic [ADR_W-1:0] OFF_TCON = 4'hC;

  // Field positions in timer_control.
  localparam int TCON_RUN = 7;
  localparam int TCON_WIDTH = 6;
  localparam int TCON_SRC = 5;
  localparam int TCON_EDGE = 4;
  localparam int TCON_BYPASS = 3;
  localparam int TCON_PS_LSB = 0;

  // Field positions in interrupt_control.
  localparam int INTC_IE = 5;
  localparam int INTC_IF = 2;

  // Byte lane that carries every register.
  localparam int LANE_LOW = 0;

  // Reset values.
  localparam logic [BYTE_W-1:0] TCON_RESET = 8'hFF;
  localparam logic [BYTE_W-1:0] HIGH_BUF_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] LOW_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] HIGH_RESET = 8'h00;

  // Counting constants.
  localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [BYTE_W-1:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [PSC_W-1:0] PSC_ZERO = 8'h00;
  localparam logic [PSC_W-1:0] PSC_ONE = 8'h01;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] INHIBIT_STEP = 2'h1;
  localparam logic [1:0] INHIBIT_NONE = 2'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0;

endpackage

// ===== inc/ptc_psc_if.sv
// Link between the counter core and its prescaler.
interface ptc_psc_if;
  logic tick;
  logic clear;
  logic bypass;
  logic [ptc_pkg::PS_W-1:0] ratio_sel;
  logic out_tick;

  modport timer (
    output tick,
    output clear,
    output bypass,
    output ratio_sel,
    input out_tick
  );

  modport psc (
    input tick,
    input clear,
    input bypass,
    input ratio_sel,
    output out_tick
  );
endinterface

// ===== logic/ptc_prescaler.sv
module ptc_prescaler #(
  parameter int PSC_W = ptc_pkg::PSC_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  ptc_psc_if.psc psc
);
  import ptc_pkg::*;

  logic [PSC_W-1:0] psc_count;

  // Mask of the low count bits that must all be set for one output tick.
  // The shift amount is one bit wider than the code, or code 111 would wrap to a shift of zero.
  function automatic logic [PSC_W-1:0] ratio_mask(input logic [PS_W-1:0] sel);
    logic [PSC_W:0] wide;
    wide = {{PSC_W{1'b0}}, 1'b1} << ((PS_W + 1)'(sel) + 1'b1);
    ratio_mask = wide[PSC_W-1:0] - PSC_ONE[PSC_W-1:0];
    return ratio_mask;
  endfunction

  // Bypass passes ticks straight on; otherwise one tick per 2**(sel+1) input ticks.
  always_comb begin
    if (psc.bypass) begin
      psc.out_tick = psc.tick;
    end else begin
      psc.out_tick = psc.tick && ((psc_count & ratio_mask(psc.ratio_sel)) == ratio_mask(psc.ratio_sel));
    end
  end

  // The count has no bus path; a power-of-two ratio lets it wrap freely. Clear wins over a tick.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psc_count <= PSC_ZERO[PSC_W-1:0];
    end else if (clk_en) begin
      if (psc.clear) begin
        psc_count <= PSC_ZERO[PSC_W-1:0];
      end else if (psc.tick && !psc.bypass) begin
        psc_count <= psc_count + PSC_ONE[PSC_W-1:0];
      end
    end
  end
endmodule

// ===== bench/ptc_timer_asserts.sv
module ptc_timer_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [ptc_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [ptc_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [ptc_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic external_count_pin,
  input wire logic sleep_mode,
  input wire logic overflow_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A request that the slave takes at this edge.
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  endsequence
  // A taken write that turns the overflow request enable off.
  sequence s_mask;
    s_take ##1 (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_INTC && !wb_dat_i[INTC_IE]);
  endsequence
  chk_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  chk_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  chk_sleep_quiet: assert property (sleep_mode && clk_en |=> !overflow_irq)
    else $error("overflow request during sleep");
  chk_irq_sticky: assert property (overflow_irq && !sleep_mode && !(wb_cyc_i && wb_we_i && wb_adr_i == OFF_INTC) |=> overflow_irq)
    else $error("overflow request dropped by itself");
  chk_mask_drops: assert property (s_mask |=> !overflow_irq)
    else $error("masked overflow request still high");
endmodule

bind ptc_timer ptc_timer_chk u_ptc_timer_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_count_pin(external_count_pin),
  .sleep_mode(sleep_mode), .overflow_irq(overflow_irq));

// ===== bench/ptc_pulse_src.sv
module ptc_pulse_src (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [3:0] toggles,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;
  logic [1:0] hold;
  // Each level stands three cycles, so the pin never changes faster than the synchroniser can see.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {pin, busy, left, hold} <= '0;
    end else if (start && !busy) begin
      {busy, left, hold} <= {1'b1, toggles, 2'h2};
    end else if (busy) begin
      if (hold != 2'h0)
        hold <= hold - 2'h1;
      else if (left == 4'h0)
        busy <= 1'b0;
      else
        {pin, left, hold} <= {!pin, left - 4'h1, 2'h2};
    end
  end
endmodule

// ===== bench/ptc_timer_tb_top.sv
module ptc_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptc_pkg::*;
  logic clk, reset_n, clk_en, cyc, stb, we, sleep_mode, go, ack, pin, busy, irq;
  logic [ADR_W-1:0] adr;
  logic [SEL_W-1:0] sel;
  logic [DATA_W-1:0] dat, rdat, v, p;
  logic [BYTE_W-1:0] d;
  int failures, n_checks;

  ptc_timer u_ptc_timer (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_count_pin(pin), .sleep_mode(sleep_mode), .overflow_irq(irq));
  ptc_pulse_src u_ptc_pulse_src (.clk(clk), .reset_n(reset_n), .start(go), .toggles(4'h5), .pin(pin),
    .busy(busy));

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string name, logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high, and read data is taken there.
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [BYTE_W-1:0] wd);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, wd};
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk);
    if (ack !== 1'b1) begin
      failures++;
      test_done();
    end
    v = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  // Five pin toggles from the present level, then time for the synchroniser to settle.
  task automatic pulse();
    int i;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 100 && busy !== 1'b0; i++)
      @(posedge clk);
    if (busy !== 1'b0) begin
      failures++;
      test_done();
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic t_reset();
    bus(1'b0, OFF_TCON, 8'h00);
    chk("tcon", v, TCON_RESET);
    bus(1'b0, OFF_HIGH, 8'h00);
    chk("high", v, HIGH_BUF_RESET);
    bus(1'b1, 4'h2, 8'h5A);
    bus(1'b0, 4'h2, 8'h00);
    chk("hole", v, 0);
  endtask

  // Accesses are taken three edges apart, so the second read sees three more cycles.
  task automatic t_count();
    bus(1'b1, OFF_TCON, 8'hC8);
    bus(1'b1, OFF_LOW, 8'h10);
    bus(1'b0, OFF_LOW, 8'h00);
    chk("inhibit", v, 8'h10);
    bus(1'b0, OFF_LOW, 8'h00);
    chk("per_cycle", v, 8'h13);
    bus(1'b1, OFF_TCON, 8'h48);
    bus(1'b0, OFF_LOW, 8'h00);
    p = v;
    bus(1'b0, OFF_LOW, 8'h00);
    chk("halt", v, p);
  endtask

  task automatic t_ovf();
    bus(1'b1, OFF_INTC, 8'h20);
    bus(1'b1, OFF_LOW, 8'hFE);
    bus(1'b1, OFF_TCON, 8'hC8);
    bus(1'b1, OFF_TCON, 8'h48);
    chk("irq", irq, 1);
    bus(1'b0, OFF_INTC, 8'h00);
    chk("flag8", v, 8'h24);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    chk("sleep", irq, 0);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clk);
    chk("wake", irq, 1);
    bus(1'b1, OFF_INTC, 8'h04);
    @(posedge clk);
    chk("mask", irq, 0);
    bus(1'b0, OFF_INTC, 8'h00);
    chk("kept", v, 8'h04);
    bus(1'b1, OFF_INTC, 8'h00);
    bus(1'b0, OFF_INTC, 8'h00);
    chk("clear", v, 0);
    bus(1'b1, OFF_TCON, 8'h08);
    bus(1'b0, OFF_LOW, 8'h00);
    bus(1'b0, OFF_HIGH, 8'h00);
    chk("high8", v, 0);
  endtask

  task automatic t_wide();
    bus(1'b1, OFF_HIGH, 8'hAB);
    bus(1'b1, OFF_LOW, 8'hCD);
    bus(1'b1, OFF_HIGH, 8'h00);
    bus(1'b0, OFF_LOW, 8'h00);
    chk("low16", v, 8'hCD);
    bus(1'b0, OFF_HIGH, 8'h00);
    chk("high16", v, 8'hAB);
    bus(1'b1, OFF_HIGH, 8'hFF);
    bus(1'b1, OFF_LOW, 8'hFF);
    bus(1'b1, OFF_TCON, 8'h88);
    bus(1'b1, OFF_TCON, 8'h08);
    bus(1'b0, OFF_INTC, 8'h00);
    chk("flag16", v, 8'h04);
    bus(1'b0, OFF_LOW, 8'h00);
    bus(1'b0, OFF_HIGH, 8'h00);
    chk("wrap16", v, 0);
  endtask

  // Ratio is changed while running; a window of 8 << k cycles at ratio 2 << k holds exactly four ticks.
  task automatic t_psc();
    int k;
    for (k = 0; k < 8; k++) begin
      bus(1'b1, OFF_TCON, 8'hC0 | 8'(k));
      bus(1'b0, OFF_LOW, 8'h00);
      p = v;
      repeat ((8 << k) - 3) @(posedge clk);
      bus(1'b0, OFF_LOW, 8'h00);
      d = v[7:0] - p[7:0];
      chk("ratio", d, 4);
    end
    bus(1'b1, OFF_LOW, 8'h00);
    repeat (200) @(posedge clk);
    bus(1'b1, OFF_LOW, 8'h00);
    repeat (200) @(posedge clk);
    bus(1'b0, OFF_LOW, 8'h00);
    chk("psc_clear", v, 0);
  endtask

  task automatic t_pin();
    bus(1'b1, OFF_TCON, 8'hE8);
    bus(1'b1, OFF_LOW, 8'h00);
    pulse();
    bus(1'b0, OFF_LOW, 8'h00);
    chk("rise", v, 3);
    bus(1'b1, OFF_TCON, 8'hF8);
    bus(1'b1, OFF_LOW, 8'h00);
    pulse();
    bus(1'b0, OFF_LOW, 8'h00);
    chk("fall", v, 3);
  endtask

  // The enable is dropped between two reads; only the edges with it high may count.
  task automatic t_freeze();
    bus(1'b1, OFF_TCON, 8'hC8);
    bus(1'b0, OFF_LOW, 8'h00);
    p = v;
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    bus(1'b0, OFF_LOW, 8'h00);
    d = v[7:0] - p[7:0];
    chk("freeze", d, 3);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {reset_n, clk_en, cyc, stb, we, sleep_mode, go} = 7'b0100000;
    {adr, sel, dat} = {4'h0, 4'hF, 32'h0};
    failures = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_count();
    t_ovf();
    t_wide();
    t_psc();
    t_pin();
    t_freeze();
    test_done();
  end
endmodule
